/* File: rtl/amlc_pkg.sv */
// constants and carrier types of the alert mask and limit register slice
package amlc_pkg;
	localparam logic [7:0] ADDR_MASK_THREE    = 8'h82;
	localparam logic [7:0] ADDR_MASK_FOUR     = 8'h83;
	localparam logic [7:0] ADDR_TV_LOW        = 8'h84;
	localparam logic [7:0] ADDR_CM_LOW        = 8'h85;
	localparam logic [7:0] ADDR_TV_HIGH       = 8'h86;
	localparam logic [7:0] ADDR_CM_HIGH       = 8'h87;
	localparam logic [7:0] ADDR_LINK_CFG_TWO  = 8'h88;
	localparam logic [7:0] ADDR_STATUS_FOUR   = 8'h81;
	localparam logic [7:0] RST_MASK           = 8'h00;
	localparam logic [7:0] RST_LOW_LIMIT      = 8'h00;
	localparam logic [7:0] RST_HIGH_LIMIT     = 8'hff;
	localparam logic [7:0] RST_LINK_CFG       = 8'h00;
	localparam logic [6:0] CLIENT_ADDR_BASE   = 7'h30;
	// first mask register bits
	localparam int M3_CPU_FIRST   = 0;
	localparam int M3_DATA_ERR    = 1;
	localparam int M3_LINK_ERR    = 2;
	localparam int M3_OVERTEMP    = 3;
	localparam int M3_SUMMARY     = 7;
	// second mask / status register bits
	localparam int M4_CPU_SECOND  = 3;
	localparam int M4_CPU_THIRD   = 4;
	localparam int M4_CPU_FOURTH  = 5;
	localparam int M4_CURRENT_MON = 6;
	localparam int M4_TERM_VOLT   = 7;
	// processor link config bits
	localparam int CFG_DOM_FOURTH = 3;
	localparam int CFG_DOM_THIRD  = 4;
	localparam int CFG_DOM_SECOND = 5;
	localparam int CFG_COUNT_LSB  = 6;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} amlc_req_t;

	typedef struct packed {
		logic [3:0] cpu_oor;
		logic       data_err;
		logic       link_err;
		logic       overtemp_pin;
		logic       summary;
	} amlc_event_t;
endpackage

/* File: rtl/amlc_limit_flag.sv */
// sticky out-of-limit flag for one monitored channel
`timescale 1ns/1ps
`default_nettype none
module amlc_limit_flag #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	// channel
	input  wire logic         sample_i,
	input  wire logic [W-1:0] reading_i,
	input  wire logic [W-1:0] low_i,
	input  wire logic [W-1:0] high_i,
	input  wire logic         clear_i,
	// flag
	output logic              flag_o
);
	if (W < 1)
	begin : g_width_check
		$error("width must be positive");
	end

	logic flag_r;
	logic flag_nxt;
	logic outside;
	logic cond_r;

	// strictly beyond either limit counts as a violation
	assign outside = (reading_i > high_i) || (reading_i < low_i);
	// a read clears only once the condition has gone; new violation wins
	assign flag_nxt = (sample_i && outside) ? 1'b1 :
		(clear_i && !cond_r) ? 1'b0 : flag_r;
	assign flag_o = flag_r;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			flag_r <= 1'b0;
			cond_r <= 1'b0;
		end
		else
		begin
			flag_r <= flag_nxt;
			if (sample_i)
				cond_r <= outside;
		end
	end
endmodule
`default_nettype wire

/* File: rtl/amlc_regs.sv */
// alert mask, limit and processor link configuration register slice
// Behaviour
// [RULE1] mask bit 0 hides first processor alerts
// [RULE2] mask bit 1 hides processor data errors
// [RULE3] mask bit 2 hides processor link errors
// [RULE4] mask bit 3 hides overtemperature pin alerts
// [RULE5] mask bit 7 hides summary flag alerts
// [RULE6] summary mask acts independently of second mask
// [RULE7] second mask bits 3-5 hide processors 2-4
// [RULE8] bit 6 current, bit 7 voltage masks
// [RULE9] low limits reset 00, high limits ff
// [RULE10] lock makes limits and config read-only
// [RULE11] domain bit: 0 single, 1 two domains
// [RULE12] count field selects processors, clients 30-33
// [RULE13] flags set on violation, read clears if gone
// [RULE14] alert asserted while any unmasked condition
`timescale 1ns/1ps
`default_nettype none
module amlc_regs #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 reset_i,
	// register access from the serial host
	input  wire amlc_pkg::amlc_req_t  req_i,
	output logic [7:0]                rdata_o,
	// lock bit of the first configuration register
	input  wire logic                 lock_i,
	// events from the measurement engine
	input  wire amlc_pkg::amlc_event_t event_i,
	input  wire logic                 sample_i,
	input  wire logic [W-1:0]         term_voltage_i,
	input  wire logic [W-1:0]         current_monitor_i,
	// configuration seen by the processor interface
	output logic [2:0]                cpu_count_o,
	output logic [3:0]                client_enable_o,
	output logic [6:0]                client_last_addr_o,
	output logic [3:0]                two_domain_o,
	// status and alert
	output logic [7:0]                status_four_o,
	output logic                      alert_o
);
	// the register file and the limit compare share one byte width
	if (W != 8)
	begin : g_width_check
		$error("limit registers are eight bits wide");
	end

	////////////////////////////////////////////////////////////////////////
	logic [7:0] mask_three_r;
	logic [7:0] mask_four_r;
	logic [7:0] tv_low_r;
	logic [7:0] cm_low_r;
	logic [7:0] tv_high_r;
	logic [7:0] cm_high_r;
	logic [7:0] link_cfg_r;
	logic [7:0] rdata_r;
	logic       tv_flag;
	logic       cm_flag;
	logic       status_rd;
	logic [7:0] status_four;
	logic [7:0] rdata_nxt;
	logic [1:0] cpu_field;
	logic       wr_mask_three;
	logic       wr_mask_four;
	logic       wr_tv_low;
	logic       wr_cm_low;
	logic       wr_tv_high;
	logic       wr_cm_high;
	logic       wr_link_cfg;

	function automatic logic hit(input amlc_pkg::amlc_req_t r,
		input logic [7:0] a);
		hit = r.wr && (r.addr == a);
	endfunction

	// masks stay writable under lock; only limits and config freeze
	assign wr_mask_three = hit(req_i, amlc_pkg::ADDR_MASK_THREE);
	assign wr_mask_four  = hit(req_i, amlc_pkg::ADDR_MASK_FOUR);
	// [RULE10] lock gates writes
	assign wr_tv_low     = !lock_i
		&& hit(req_i, amlc_pkg::ADDR_TV_LOW);
	assign wr_cm_low     = !lock_i
		&& hit(req_i, amlc_pkg::ADDR_CM_LOW);
	assign wr_tv_high    = !lock_i
		&& hit(req_i, amlc_pkg::ADDR_TV_HIGH);
	assign wr_cm_high    = !lock_i
		&& hit(req_i, amlc_pkg::ADDR_CM_HIGH);
	assign wr_link_cfg   = !lock_i
		&& hit(req_i, amlc_pkg::ADDR_LINK_CFG_TWO);
	// reading the status register is what may clear a flag
	assign status_rd = req_i.rd && (req_i.addr == amlc_pkg::ADDR_STATUS_FOUR);

	////////////////////////////////////////////////////////////////////////
	// [RULE9] limit reset values
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			mask_three_r <= amlc_pkg::RST_MASK;
			mask_four_r  <= amlc_pkg::RST_MASK;
			tv_low_r     <= amlc_pkg::RST_LOW_LIMIT;
			cm_low_r     <= amlc_pkg::RST_LOW_LIMIT;
			tv_high_r    <= amlc_pkg::RST_HIGH_LIMIT;
			cm_high_r    <= amlc_pkg::RST_HIGH_LIMIT;
			link_cfg_r   <= amlc_pkg::RST_LINK_CFG;
		end
		else
		begin
			if (wr_mask_three)
				mask_three_r <= req_i.wdata;
			if (wr_mask_four)
				mask_four_r <= req_i.wdata;
			// [RULE10] locked registers
			if (wr_tv_low)
				tv_low_r <= req_i.wdata;
			if (wr_cm_low)
				cm_low_r <= req_i.wdata;
			if (wr_tv_high)
				tv_high_r <= req_i.wdata;
			if (wr_cm_high)
				cm_high_r <= req_i.wdata;
			if (wr_link_cfg)
				link_cfg_r <= req_i.wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// [RULE13] voltage and current flags
	amlc_limit_flag #(.W(W)) u_tv_flag (
		.clk_i     (clk_i),
		.reset_i   (reset_i),
		.sample_i  (sample_i),
		.reading_i (term_voltage_i),
		.low_i     (tv_low_r),
		.high_i    (tv_high_r),
		.clear_i   (status_rd),
		.flag_o    (tv_flag)
	);

	amlc_limit_flag #(.W(W)) u_cm_flag (
		.clk_i     (clk_i),
		.reset_i   (reset_i),
		.sample_i  (sample_i),
		.reading_i (current_monitor_i),
		.low_i     (cm_low_r),
		.high_i    (cm_high_r),
		.clear_i   (status_rd),
		.flag_o    (cm_flag)
	);

	// processor flags arrive already sticky from the processor interface
	assign status_four = {tv_flag, cm_flag, event_i.cpu_oor[3:1], 3'h0};
	assign status_four_o = status_four;

	////////////////////////////////////////////////////////////////////////
	// [RULE11] domain bits per processor
	assign two_domain_o = {link_cfg_r[amlc_pkg::CFG_DOM_FOURTH],
		link_cfg_r[amlc_pkg::CFG_DOM_THIRD],
		link_cfg_r[amlc_pkg::CFG_DOM_SECOND], 1'b0};
	// [RULE12] count field decode
	// field 00 means one processor, 11 means four
	assign cpu_field = link_cfg_r[amlc_pkg::CFG_COUNT_LSB +: 2];
	assign cpu_count_o = {1'b0, cpu_field} + 3'h1;
	// the four-bit shift wraps to zero for four, leaving all ones
	assign client_enable_o = (4'h2 << cpu_field) - 4'h1;
	assign client_last_addr_o = amlc_pkg::CLIENT_ADDR_BASE
		+ {5'h00, cpu_field};

	////////////////////////////////////////////////////////////////////////
	logic hit_three;
	logic hit_four;
	logic hit_sum;

	// first mask terms act on the event levels directly
	// [RULE1] first processor mask
	// [RULE2] data error mask
	// [RULE3] link error mask
	// [RULE4] overtemperature mask
	assign hit_three =
		(event_i.cpu_oor[0] && !mask_three_r[amlc_pkg::M3_CPU_FIRST]) ||
		(event_i.data_err && !mask_three_r[amlc_pkg::M3_DATA_ERR]) ||
		(event_i.link_err && !mask_three_r[amlc_pkg::M3_LINK_ERR]) ||
		(event_i.overtemp_pin && !mask_three_r[amlc_pkg::M3_OVERTEMP]);
	// [RULE7] processor masks
	// [RULE8] current and voltage masks
	assign hit_four = |(status_four & ~mask_four_r);
	// [RULE5] summary mask
	// [RULE6] summary independent of second mask
	assign hit_sum = (event_i.summary || (|status_four))
		&& !mask_three_r[amlc_pkg::M3_SUMMARY];

	// [RULE14] alert combination
	// a status bit stays quiet only under both its own and the summary
	// mask, since either path alone raises the alert
	assign alert_o = hit_three || hit_four || hit_sum;

	////////////////////////////////////////////////////////////////////////
	// unmapped addresses read as zero; status is taken before any clear
	assign rdata_nxt =
		(req_i.addr == amlc_pkg::ADDR_STATUS_FOUR)  ? status_four :
		(req_i.addr == amlc_pkg::ADDR_MASK_THREE)   ? mask_three_r :
		(req_i.addr == amlc_pkg::ADDR_MASK_FOUR)    ? mask_four_r :
		(req_i.addr == amlc_pkg::ADDR_TV_LOW)       ? tv_low_r :
		(req_i.addr == amlc_pkg::ADDR_CM_LOW)       ? cm_low_r :
		(req_i.addr == amlc_pkg::ADDR_TV_HIGH)      ? tv_high_r :
		(req_i.addr == amlc_pkg::ADDR_CM_HIGH)      ? cm_high_r :
		(req_i.addr == amlc_pkg::ADDR_LINK_CFG_TWO) ? link_cfg_r :
		8'h00;

	// read data stands until the next read
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			rdata_r <= 8'h00;
		else if (req_i.rd)
			rdata_r <= rdata_nxt;
	end
	assign rdata_o = rdata_r;
endmodule
`default_nettype wire

/* File: verification/amlc_regs_props.sv */
// alert relation checker for the register slice
`timescale 1ns/1ps
`default_nettype none
module amlc_regs_props (
	// clock, reset and watched ports
	input wire logic                  clk_i,
	input wire logic                  reset_i,
	input wire amlc_pkg::amlc_req_t   req_i,
	input wire logic                  lock_i,
	input wire amlc_pkg::amlc_event_t event_i,
	input wire logic [2:0]            cpu_count_o,
	input wire logic [7:0]            status_four_o,
	input wire logic                  alert_o
);
	// mask shadows, so alerts are judged against what was written
	logic [7:0] m3_r;
	logic [7:0] m4_r;
	wire [7:0]  ev = event_i;
	wire        w3 = req_i.wr && req_i.addr == 8'h82;
	wire        w4 = req_i.wr && req_i.addr == 8'h83;
	wire        s4 = |(status_four_o & ~m4_r);
	wire        hit = |(ev[4:1] & ~{m3_r[0], m3_r[1], m3_r[2], m3_r[3]});
	always_ff @(posedge clk_i)
	begin
		m3_r <= reset_i ? 8'h00 : w3 ? req_i.wdata : m3_r;
		m4_r <= reset_i ? 8'h00 : w4 ? req_i.wdata : m4_r;
	end
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	chk_first_alert:
	assert property (ev[4] && !m3_r[0] |-> alert_o) else $error("cpu alert");
	chk_data_alert:
	assert property (ev[3] && !m3_r[1] |-> alert_o) else $error("data alert");
	chk_link_alert:
	assert property (ev[2] && !m3_r[2] |-> alert_o) else $error("link");
	chk_ovt_alert:
	assert property (ev[1] && !m3_r[3] |-> alert_o) else $error("overtemp");
	chk_summary_alert:
	assert property (ev[0] && !m3_r[7] |-> alert_o) else $error("summary");
	chk_status_alert:
	assert property ((|status_four_o) && !m3_r[7] |-> alert_o)
	else $error("status alert");
	chk_own_alert:
	assert property (s4 |-> alert_o) else $error("unmasked status alert");
	chk_alert_cause:
	assert property (alert_o |-> hit || s4 ||
		!m3_r[7] && ((|status_four_o) || ev[0]))
	else $error("alert without cause");
	chk_lock_cfg:
	assert property (lock_i && w3 == 0 && req_i.wr && req_i.addr == 8'h88
		|=> $stable(cpu_count_o)) else $error("locked config changed");
endmodule
`default_nettype wire

/* File: verification/amlc_host.sv */
// register host model: one byte per request, held over its edge
`timescale 1ns/1ps
`default_nettype none
module amlc_host (
	// clock and read data
	input wire logic               clk_i,
	input wire logic [7:0]         rdata_i,
	// request to the slice
	output var amlc_pkg::amlc_req_t req_o
);
	initial req_o = '0;
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge clk_i);
		req_o = {w, !w, a, d};
		@(negedge clk_i);
		q = rdata_i;
		// released lines show inverted bits, never the old value
		req_o = {2'b00, ~a, ~d};
	endtask
endmodule
`default_nettype wire

/* File: verification/amlc_regs_tb.sv */
// self-checking bench for the alert mask and limit register slice
`timescale 1ns/1ps
`default_nettype none
module amlc_regs_tb;
	logic                  clk_i = 1'b0;
	logic                  reset_i = 1'b1;
	logic                  lock_i = 1'b0;
	logic                  sample_i = 1'b0;
	logic [7:0]            term_voltage_i = 8'h00;
	logic [7:0]            current_monitor_i = 8'h00;
	amlc_pkg::amlc_event_t event_i = '0;
	amlc_pkg::amlc_req_t   req_i;
	logic [7:0]            rdata_o, status_four_o, rv, a;
	logic [2:0]            cpu_count_o;
	logic [3:0]            client_enable_o, two_domain_o;
	logic [6:0]            client_last_addr_o;
	logic                  alert_o;
	logic [17:0]           cfg;
	logic [7:0]            sh [0:6];
	logic [7:0]            evs [0:4] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01};
	logic [7:0]            mks [0:4] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h80};
	int                    miscompares = 0;
	int                    tests_run = 0;
	amlc_regs u_dut (.clk_i, .reset_i, .req_i, .rdata_o, .lock_i, .event_i,
		.sample_i, .term_voltage_i, .current_monitor_i, .cpu_count_o,
		.client_enable_o, .client_last_addr_o, .two_domain_o, .status_four_o,
		.alert_o);
	amlc_host u_host (.clk_i, .rdata_i(rdata_o), .req_o(req_i));
	initial forever #5 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [17:0] g, input logic [17:0] e);
		tests_run++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic w(input logic [7:0] ad, input logic [7:0] d);
		u_host.xfer(1'b1, ad, d, rv);
		// locked limits and config keep their value
		if (!lock_i || ad < 8'h84)
			sh[ad - 8'h82] = d;
	endtask
	task automatic rd(input logic [7:0] ad);
		u_host.xfer(1'b0, ad, 8'h00, rv);
	endtask
	task automatic pulse();
		@(negedge clk_i);
		sample_i = 1'b1;
		@(negedge clk_i);
		sample_i = 1'b0;
	endtask
	function automatic logic [17:0] cfg_exp(input logic [7:0] d);
		logic [2:0] n;
		n = {1'b0, d[7:6]} + 3'h1;
		return {n, 4'hf >> (3'h4 - n), 7'h30 + {5'h00, d[7:6]},
			d[3], d[4], d[5], 1'b0};
	endfunction
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(54090));
		sh = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};
		repeat (20) @(negedge clk_i);
		reset_i = 1'b0;
		for (int i = 0; i < 7; i++)
		begin
			rd(8'h82 + 8'(i));
			chk(rv, sh[i]);
		end
		// status register ignores writes
		u_host.xfer(1'b1, 8'h81, 8'hff, rv);
		rd(8'h81);
		chk(rv, 8'h00);
		// one alert source at a time, open then masked
		for (int k = 0; k < 5; k++)
		begin
			event_i = evs[k];
			w(8'h82, 8'h00);
			chk(alert_o, 1'b1);
			w(8'h82, mks[k]);
			chk(alert_o, 1'b0);
		end
		// processor status bits raise the alert past a masked summary
		event_i = 8'he0;
		w(8'h82, 8'h00);
		chk(alert_o, 1'b1);
		w(8'h82, 8'h80);
		chk(alert_o, 1'b1);
		w(8'h83, 8'h38);
		chk(alert_o, 1'b0);
		event_i = '0;
		rd(8'h81);
		w(8'h82, 8'h00);
		w(8'h83, 8'h00);
		w(8'h86, 8'h80);
		w(8'h85, 8'h20);
		term_voltage_i = 8'h90;
		current_monitor_i = 8'h10;
		pulse();
		chk(status_four_o & 8'hc0, 8'hc0);
		w(8'h83, 8'hc0);
		chk(alert_o, 1'b1);
		w(8'h82, 8'h80);
		chk(alert_o, 1'b0);
		rd(8'h81);
		chk(rv, 8'hc0);
		chk(status_four_o & 8'hc0, 8'hc0);
		term_voltage_i = 8'h50;
		current_monitor_i = 8'h50;
		pulse();
		rd(8'h81);
		chk(status_four_o & 8'hc0, 8'h00);
		w(8'h88, 8'hff);
		for (int i = 0; i < 40; i++)
		begin
			lock_i = (i >= 20);
			a = 8'h82 + 8'($urandom_range(6));
			w(a, 8'($urandom));
			rd(a);
			chk(rv, sh[a - 8'h82]);
			cfg = {cpu_count_o, client_enable_o, client_last_addr_o, two_domain_o};
			chk(cfg, cfg_exp(sh[6]));
		end
		// a second reset in mid-run restores every register, while the bench drives the lock low itself
		@(negedge clk_i);
		reset_i = 1'b1;
		lock_i = 1'b0;
		repeat (2) @(negedge clk_i);
		reset_i = 1'b0;
		sh = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};
		cfg = {cpu_count_o, client_enable_o, client_last_addr_o, two_domain_o};
		chk(cfg, cfg_exp(8'h00));
		for (int i = 0; i < 7; i++)
		begin
			rd(8'h82 + 8'(i));
			chk(rv, sh[i]);
		end
		print_verdict();
	end
	initial
	begin
		#100000;
		miscompares++;
		$display("unexpected at %0t: watchdog expired", $time);
		print_verdict();
	end
endmodule
bind amlc_regs amlc_regs_props u_chk (.clk_i, .reset_i, .req_i, .lock_i,
	.event_i, .cpu_count_o, .status_four_o, .alert_o);
`default_nettype wire
